// ---- verilog/pmw_pkg.sv ----
// Constants, register map and carrier types for the power mode and wake control block.
// Assumes one 250 MHz clock and a classic Wishbone master with 32-bit data.
package pmw_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_PORTS = 5;
    localparam int ADDR_BYTES = 6;
    localparam int SYNC_BYTES = 6;
    localparam int ADDR_REPS = 16;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADR_PWR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PORT_PD = 8'h04;
    localparam logic [7:0] ADR_QUIET = 8'h08;
    localparam logic [7:0] ADR_WAKE_CFG = 8'h0C;
    localparam logic [7:0] ADR_WAKE_STAT = 8'h10;
    localparam logic [7:0] ADR_NODE_LO = 8'h14;
    localparam logic [7:0] ADR_NODE_HI = 8'h18;
    localparam logic [7:0] ADR_STATUS = 8'h1C;

    // ==========================================================
    // Fields
    localparam int MODE_LSB = 3;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ENERGY_DETECT_POWER_DOWN = 2'h1;
    localparam logic [1:0] MODE_SOFT = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam int WCFG_EN_ENERGY = 8;
    localparam int WCFG_EN_LINK = 9;
    localparam int WCFG_EN_PATTERN = 10;
    localparam int WCFG_PME_EN = 11;
    localparam int WCFG_ROUTE_INT = 12;
    localparam int ST_ENERGY = 0;
    localparam int ST_LINK = 1;
    localparam int ST_PATTERN = 2;
    localparam int STAT_LOW_BIT = 2;
    localparam int STAT_STRAP_LSB = 8;

    // ==========================================================
    // Values after reset
    localparam logic [1:0] MODE_RST = MODE_NORMAL;
    localparam logic [4:0] PORT_PD_RST = 5'h00;
    localparam logic [23:0] QUIET_RST = 24'h00_0400;
    localparam logic [12:0] WAKE_CFG_RST = 13'h000A;
    // Node address reset value is arbitrary.
    localparam logic [47:0] NODE_ADDR_RST = 48'h0000_0000_0000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int ENERGY_PRESENT_NS = 100;
    localparam int ENERGY_PRESENT_CYC = (ENERGY_PRESENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_PERIOD_NS = 40;
    localparam int REF_DIV_CYC = REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_PULSE_NS = 16000;
    localparam int LINK_PULSE_CYC = LINK_PULSE_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pmw_wb_req_t;

    function automatic logic [31:0] pmw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] pmw_addr_byte(input logic [47:0] addr,
                                                 input logic [2:0] idx);
        return addr[8'(47 - 8 * int'(idx)) -: 8];
    endfunction
endpackage

// ---- verilog/pmw_power_wake.sv ----
// Global power mode sequencer, per-port power down and wake event detection.
// Assumes a classic Wishbone master on the same clock; PHY levels and straps are asynchronous.
`timescale 1ns/100ps
module pmw_power_wake
    import pmw_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire pmw_wb_req_t wb_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [NUM_PORTS-1:0] cable_energy_in,
    input wire logic [NUM_PORTS-1:0] link_up_in,
    input wire logic [3:0] strap_in,
    input wire logic rx_valid_in,
    input wire logic rx_sof_in,
    input wire logic [7:0] rx_data_in,
    output logic pll_enable_out,
    output logic mac_enable_out,
    output logic host_if_enable_out,
    output logic [NUM_PORTS-1:0] phy_enable_out,
    output logic [NUM_PORTS-1:0] energy_detect_out,
    output logic link_pulse_out,
    output logic [3:0] strap_config_out,
    output logic power_event_out_n,
    output logic interrupt_out_n
);
    // ==========================================================
    // Synchronisers
    logic [NUM_PORTS-1:0] energy_m_q, energy_s_q, link_m_q, link_s_q, link_prev_q;
    logic [3:0] strap_m_q, strap_s_q;

    always_ff @(posedge clock_in)
    begin
        energy_m_q <= cable_energy_in;
        energy_s_q <= energy_m_q;
        link_m_q <= link_up_in;
        link_s_q <= link_m_q;
        strap_m_q <= strap_in;
        strap_s_q <= strap_m_q;
    end

    // ==========================================================
    // Registers
    logic soft_rst_q, srst;
    logic [1:0] mode_q;
    logic [4:0] port_pd_q;
    logic [23:0] quiet_q;
    logic [12:0] wcfg_q;
    logic [2:0] wstat_q, wstat_d;
    logic [47:0] node_q;
    logic low_q, ack_q;
    logic [31:0] rdat_q;
    logic [3:0] strap_cfg_q;
    logic strap_load_q;

    // Soft reset returns every register but the bus slave, strap latch and synchronisers to its default as soft power down ends.
    assign srst = rst_in | soft_rst_q;

    wire acc = wb_in.cyc & wb_in.stb & ~ack_q;
    // Writes land at the edge that samples ack high, the one at which the master takes the answer.
    wire wr = wb_in.cyc & wb_in.stb & wb_in.we & ack_q;
    wire wr_ctrl = wr && wb_in.adr == ADR_PWR_CTRL && wb_in.sel[0];
    wire wr_pd = wr && wb_in.adr == ADR_PORT_PD;
    wire wr_quiet = wr && wb_in.adr == ADR_QUIET;
    wire wr_wcfg = wr && wb_in.adr == ADR_WAKE_CFG;
    wire wr_wstat = wr && wb_in.adr == ADR_WAKE_STAT && wb_in.sel[0];
    wire wr_nlo = wr && wb_in.adr == ADR_NODE_LO;
    wire wr_nhi = wr && wb_in.adr == ADR_NODE_HI;
    wire [1:0] mode_wr = wb_in.dat[MODE_LSB +: 2];
    // Code 11 is reserved and leaves the mode alone.
    wire mode_take = wr_ctrl && mode_wr != MODE_RSVD;
    wire soft_exit = mode_take && mode_q == MODE_SOFT && mode_wr != MODE_SOFT;

    wire [31:0] pd_w = pmw_merge({27'h000_0000, port_pd_q}, wb_in.dat, wb_in.sel);
    wire [31:0] quiet_w = pmw_merge({8'h00, quiet_q}, wb_in.dat, wb_in.sel);
    wire [31:0] wcfg_w = pmw_merge({19'h0_0000, wcfg_q}, wb_in.dat, wb_in.sel);
    wire [31:0] nlo_w = pmw_merge(node_q[31:0], wb_in.dat, wb_in.sel);
    wire [31:0] nhi_w = pmw_merge({16'h0000, node_q[47:32]}, wb_in.dat, wb_in.sel);

    always_ff @(posedge clock_in)
    begin
        if (srst)
        begin
            mode_q <= MODE_RST;
            port_pd_q <= PORT_PD_RST;
            quiet_q <= QUIET_RST;
            wcfg_q <= WAKE_CFG_RST;
            node_q <= NODE_ADDR_RST;
        end
        else
        begin
            if (mode_take && !soft_exit)
            begin
                mode_q <= mode_wr;
            end
            if (wr_pd)
            begin
                port_pd_q <= pd_w[4:0];
            end
            if (wr_quiet)
            begin
                quiet_q <= quiet_w[23:0];
            end
            if (wr_wcfg)
            begin
                wcfg_q <= wcfg_w[12:0];
            end
            if (wr_nlo)
            begin
                node_q[31:0] <= nlo_w;
            end
            if (wr_nhi)
            begin
                node_q[47:32] <= nhi_w[15:0];
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            soft_rst_q <= 1'b0;
            strap_load_q <= 1'b1;
            strap_cfg_q <= 4'h0;
        end
        else
        begin
            soft_rst_q <= soft_exit;
            strap_load_q <= soft_rst_q;
            if (strap_load_q)
            begin
                strap_cfg_q <= strap_s_q;
            end
        end
    end

    // ==========================================================
    // Wishbone slave: one wait state, unmapped reads return zero.
    // The management port stays served in every mode.
    wire [31:0] status_v = {20'h0_0000, strap_cfg_q, 5'h00, low_q, mode_q};
    wire [31:0] rd_mux =
        (wb_in.adr == ADR_PWR_CTRL) ? {27'h000_0000, mode_q, 3'h0} :
        (wb_in.adr == ADR_PORT_PD) ? {27'h000_0000, port_pd_q} :
        (wb_in.adr == ADR_QUIET) ? {8'h00, quiet_q} :
        (wb_in.adr == ADR_WAKE_CFG) ? {19'h0_0000, wcfg_q} :
        (wb_in.adr == ADR_WAKE_STAT) ? {29'h0000_0000, wstat_q} :
        (wb_in.adr == ADR_NODE_LO) ? node_q[31:0] :
        (wb_in.adr == ADR_NODE_HI) ? {16'h0000, node_q[47:32]} :
        (wb_in.adr == ADR_STATUS) ? status_v : 32'h0000_0000;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= acc;
            rdat_q <= acc ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // ==========================================================
    // Reference tick and energy-detect sequencing
    logic [3:0] div_q;
    logic [23:0] quiet_cnt_q;
    logic [5:0] en_cnt_q;
    logic [11:0] pulse_cnt_q;
    logic [7:0] wen_cnt_q;

    wire ref_tick = div_q == 4'(REF_DIV_CYC - 1);
    wire [4:0] energy_live = energy_s_q & ~port_pd_q;
    wire energy_any = |energy_live;
    wire energy_detect_power_down = mode_q == MODE_ENERGY_DETECT_POWER_DOWN;
    wire go_low = energy_detect_power_down && !low_q && !energy_any && quiet_cnt_q > quiet_q;
    // Energy must already have been seen for the full 100 ns before this cycle.
    wire go_high = low_q && energy_any && en_cnt_q >= 6'(ENERGY_PRESENT_CYC);

    always_ff @(posedge clock_in)
    begin
        if (srst)
        begin
            div_q <= 4'h0;
            quiet_cnt_q <= 24'h00_0000;
            en_cnt_q <= 6'h00;
            pulse_cnt_q <= 12'h000;
            low_q <= 1'b0;
        end
        else
        begin
            div_q <= ref_tick ? 4'h0 : div_q + 4'h1;
            if (energy_any || !energy_detect_power_down || low_q)
            begin
                quiet_cnt_q <= 24'h00_0000;
            end
            else if (ref_tick && quiet_cnt_q != 24'hFF_FFFF)
            begin
                quiet_cnt_q <= quiet_cnt_q + 24'h00_0001;
            end
            if (!energy_any || !low_q)
            begin
                en_cnt_q <= 6'h00;
            end
            else if (en_cnt_q != 6'h3F)
            begin
                en_cnt_q <= en_cnt_q + 6'h01;
            end
            if (!energy_detect_power_down || go_high)
            begin
                low_q <= 1'b0;
            end
            else if (go_low)
            begin
                low_q <= 1'b1;
            end
            pulse_cnt_q <= (!low_q || pulse_cnt_q == 12'(LINK_PULSE_CYC - 1)) ? 12'h000 :
                           pulse_cnt_q + 12'h001;
        end
    end

    // ==========================================================
    // Block enables, all registered
    wire running = mode_q == MODE_NORMAL || (energy_detect_power_down && !low_q);
    always_ff @(posedge clock_in)
    begin
        if (srst)
        begin
            pll_enable_out <= 1'b1;
            mac_enable_out <= 1'b1;
            host_if_enable_out <= 1'b1;
            phy_enable_out <= {NUM_PORTS{1'b1}};
            energy_detect_out <= {NUM_PORTS{1'b0}};
            link_pulse_out <= 1'b0;
        end
        else
        begin
            pll_enable_out <= running;
            mac_enable_out <= running;
            host_if_enable_out <= running;
            // Per-port power down gates the PHY whatever the global mode.
            phy_enable_out <= running ? ~port_pd_q : {NUM_PORTS{1'b0}};
            energy_detect_out <= (energy_detect_power_down && low_q) ? ~port_pd_q : {NUM_PORTS{1'b0}};
            link_pulse_out <= low_q && pulse_cnt_q == 12'h000;
        end
    end

    assign strap_config_out = strap_cfg_q;

    // ==========================================================
    // Wake pattern matcher: bytes come from the MAC on this clock.
    logic [2:0] hdr_q, ff_q, pos_q;
    logic [3:0] rep_q;
    logic mc_q, da_eq_q, seq_q, found_q;

    wire [7:0] rb = rx_data_in;
    wire rx_on = rx_valid_in && mac_enable_out;
    wire pos_hit = rb == pmw_addr_byte(node_q, pos_q);
    wire last_copy = rep_q == 4'(ADDR_REPS - 1) && pos_q == 3'(ADDR_BYTES - 1);
    // Broadcast is a multicast address, so the group bit covers both.
    wire da_ok = mc_q || da_eq_q;

    always_ff @(posedge clock_in)
    begin
        if (srst)
        begin
            hdr_q <= 3'h0;
            ff_q <= 3'h0;
            pos_q <= 3'h0;
            rep_q <= 4'h0;
            mc_q <= 1'b0;
            da_eq_q <= 1'b0;
            seq_q <= 1'b0;
            found_q <= 1'b0;
        end
        else
        begin
            found_q <= 1'b0;
            if (rx_on && rx_sof_in)
            begin
                hdr_q <= 3'h1;
                mc_q <= rb[0];
                da_eq_q <= rb == pmw_addr_byte(node_q, 3'h0);
                ff_q <= 3'h0;
                seq_q <= 1'b0;
            end
            else if (rx_on && hdr_q < 3'(ADDR_BYTES))
            begin
                hdr_q <= hdr_q + 3'h1;
                da_eq_q <= da_eq_q && rb == pmw_addr_byte(node_q, hdr_q);
            end
            else if (rx_on && seq_q)
            begin
                if (pos_hit && last_copy)
                begin
                    seq_q <= 1'b0;
                    found_q <= da_ok;
                end
                else if (pos_hit)
                begin
                    pos_q <= (pos_q == 3'(ADDR_BYTES - 1)) ? 3'h0 : pos_q + 3'h1;
                    rep_q <= (pos_q == 3'(ADDR_BYTES - 1)) ? rep_q + 4'h1 : rep_q;
                end
                else
                begin
                    // A break in the copies restarts the search.
                    seq_q <= 1'b0;
                    ff_q <= (rb == 8'hFF) ? 3'h1 : 3'h0;
                end
            end
            else if (rx_on)
            begin
                if (rb == 8'hFF)
                begin
                    ff_q <= (ff_q == 3'(SYNC_BYTES)) ? ff_q : ff_q + 3'h1;
                end
                else if (ff_q == 3'(SYNC_BYTES) && rb == pmw_addr_byte(node_q, 3'h0))
                begin
                    seq_q <= 1'b1;
                    pos_q <= 3'h1;
                    rep_q <= 4'h0;
                    ff_q <= 3'h0;
                end
                else
                begin
                    ff_q <= 3'h0;
                end
            end
        end
    end

    // ==========================================================
    // Wake events, sticky status and event pins
    wire energy_ev = ref_tick && energy_any && wen_cnt_q == wcfg_q[7:0];
    wire link_ev = |(link_s_q & ~link_prev_q & ~port_pd_q);
    wire [2:0] ev = {found_q & wcfg_q[WCFG_EN_PATTERN],
                     link_ev & wcfg_q[WCFG_EN_LINK],
                     energy_ev & wcfg_q[WCFG_EN_ENERGY]};
    // A new event in the clearing cycle survives the clear.
    assign wstat_d = (wstat_q & ~(wr_wstat ? wb_in.dat[2:0] : 3'h0)) | ev;
    wire pend = |wstat_q && wcfg_q[WCFG_PME_EN];

    always_ff @(posedge clock_in)
    begin
        if (srst)
        begin
            link_prev_q <= {NUM_PORTS{1'b0}};
            wen_cnt_q <= 8'h00;
            wstat_q <= 3'h0;
            power_event_out_n <= 1'b1;
            interrupt_out_n <= 1'b1;
        end
        else
        begin
            link_prev_q <= link_s_q;
            if (!energy_any)
            begin
                wen_cnt_q <= 8'h00;
            end
            else if (ref_tick && wen_cnt_q != 8'hFF)
            begin
                wen_cnt_q <= wen_cnt_q + 8'h01;
            end
            wstat_q <= wstat_d;
            power_event_out_n <= !(pend && !wcfg_q[WCFG_ROUTE_INT]);
            interrupt_out_n <= !(pend && wcfg_q[WCFG_ROUTE_INT]);
        end
    end

    // ==========================================================
    // Assertions
    mode_normal_a: assert property (@(posedge clock_in) disable iff (srst)
        mode_q == MODE_NORMAL |=> pll_enable_out && mac_enable_out && phy_enable_out == ~$past(port_pd_q))
        else $error("normal mode did not enable blocks");
    reset_normal_a: assert property (@(posedge clock_in)
        $fell(rst_in) |-> mode_q == MODE_NORMAL && !low_q)
        else $error("mode not normal after reset");
    energy_detect_power_down_entry_a: assert property (@(posedge clock_in) disable iff (srst)
        wr_ctrl && mode_wr == MODE_ENERGY_DETECT_POWER_DOWN && mode_q != MODE_SOFT |=> mode_q == MODE_ENERGY_DETECT_POWER_DOWN)
        else $error("energy detect mode not entered");
    low_power_off_a: assert property (@(posedge clock_in) disable iff (srst)
        low_q && energy_detect_power_down |=> !pll_enable_out && !mac_enable_out && !host_if_enable_out)
        else $error("low power state left clocks running");
    wake_time_a: assert property (@(posedge clock_in) disable iff (srst)
        low_q && energy_detect_power_down && !wr_ctrl |=> low_q == !($past(energy_any) && $past(en_cnt_q) >= 25))
        else $error("low power exit timing wrong");
    soft_off_a: assert property (@(posedge clock_in) disable iff (srst)
        mode_q == MODE_SOFT |=> !pll_enable_out && phy_enable_out == 5'h00)
        else $error("soft power down left blocks on");
    soft_exit_a: assert property (@(posedge clock_in) disable iff (rst_in)
        soft_exit |=> soft_rst_q ##1 mode_q == MODE_NORMAL && wcfg_q == WAKE_CFG_RST)
        else $error("soft power down exit did not reset registers");
    reserved_code_a: assert property (@(posedge clock_in) disable iff (srst)
        wr_ctrl && mode_wr == MODE_RSVD |=> $stable(mode_q))
        else $error("reserved mode code changed the mode");
    sticky_event_a: assert property (@(posedge clock_in) disable iff (srst)
        |ev |=> |wstat_q ##1 (!power_event_out_n || !interrupt_out_n || !$past(pend)))
        else $error("wake event not latched or signalled");

    low_entry_c: cover property (@(posedge clock_in) disable iff (srst) $rose(low_q));
    low_exit_c: cover property (@(posedge clock_in) disable iff (srst) $fell(low_q) && energy_detect_power_down);
    pattern_c: cover property (@(posedge clock_in) disable iff (srst) found_q);
    soft_exit_c: cover property (@(posedge clock_in) disable iff (rst_in) soft_exit);
endmodule // pmw_power_wake

// ---- testbench/pmw_link_partner.sv ----
// Link partner model: sends one wake pattern frame when asked.
// Assumes the block's clock; cable energy and link levels come from the bench.
`timescale 1ns/100ps
module pmw_link_partner
    import pmw_pkg::*;
(
    input wire logic clock_in,
    input wire logic send_in,
    input wire logic [47:0] node_in,
    output logic rx_valid_out,
    output logic rx_sof_out,
    output logic [7:0] rx_data_out
);
    // ==========================================================
    // Frame sequencing
    localparam int FRAME_LEN = 6 + SYNC_BYTES + ADDR_REPS * ADDR_BYTES;
    int pos_q = -1;
    logic [7:0] idle_q = 8'h00;
    logic [7:0] addr_byte;
    always_ff @(posedge clock_in)
    begin
        idle_q <= idle_q + 8'h35;
        if (pos_q >= 0 && pos_q < FRAME_LEN - 1)
            pos_q <= pos_q + 1;
        else
            pos_q <= send_in ? 0 : -1;
    end
    // Between frames the data keeps changing, so a stale byte can never look valid.
    assign addr_byte = node_in[47 - 8 * ((pos_q - 12) % 6) -: 8];
    assign rx_valid_out = pos_q >= 0;
    assign rx_sof_out = pos_q == 0;
    assign rx_data_out = !rx_valid_out ? idle_q : (pos_q < 12) ? 8'hFF : addr_byte;
endmodule // pmw_link_partner

// ---- testbench/tb_pmw_power_wake.sv ----
// Self-checking bench for the power mode and wake control block.
// Assumes the link partner model feeds the receive byte stream.
`timescale 1ns/100ps
module tb_pmw_power_wake
    import pmw_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    pmw_wb_req_t wb_q = '0;
    logic [4:0] energy_q = 5'h1F;
    logic [4:0] link_q = 5'h00;
    logic [3:0] strap_q = 4'h0;
    logic send_q = 1'b0;
    logic [47:0] node;
    logic [4:0] pd, phy, edet;
    logic [31:0] rd, wb_dat;
    logic ack, pll, mac, host, pulse, pev_n, int_n, rxv, rxs;
    logic [7:0] rxd;
    logic [3:0] scfg;
    int n_fail = 0;
    int n_checks = 0;
    int n_pulse = 0;
    int n;

    always #2 clock_in = ~clock_in;
    always @(posedge clock_in) if (pulse === 1'b1) n_pulse++;

    pmw_power_wake pmw_power_wake_i (.clock_in(clock_in), .rst_in(rst_in), .wb_in(wb_q),
        .wb_dat_out(wb_dat), .wb_ack_out(ack), .cable_energy_in(energy_q), .link_up_in(link_q),
        .strap_in(strap_q), .rx_valid_in(rxv), .rx_sof_in(rxs), .rx_data_in(rxd),
        .pll_enable_out(pll), .mac_enable_out(mac), .host_if_enable_out(host),
        .phy_enable_out(phy), .energy_detect_out(edet), .link_pulse_out(pulse),
        .strap_config_out(scfg), .power_event_out_n(pev_n), .interrupt_out_n(int_n));
    pmw_link_partner pmw_link_partner_i (.clock_in(clock_in), .send_in(send_q),
        .node_in(node), .rx_valid_out(rxv), .rx_sof_out(rxs), .rx_data_out(rxd));

    // ==========================================================
    // Shared tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle; read data is taken at the edge that samples ack high.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int k;
        @(posedge clock_in);
        wb_q <= '{1'b1, 1'b1, we, adr, 4'hF, d};
        k = 0;
        do
        begin
            @(posedge clock_in);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = wb_dat;
        wb_q <= '0;
        if (k >= 20)
        begin
            chk("ack", 32'h0000_0001, 32'h0000_0000);
            tally_and_finish();
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        n = $urandom(32'h6c65);
        // An individual address keeps its first byte off 0xFF, which the sync scan would absorb.
        node = {16'($urandom) & 16'hFEFF, 32'($urandom)};
        strap_q <= 4'($urandom);
        pd = (5'($urandom) | 5'h01) & 5'h0F;
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        wb(0, ADR_STATUS, 32'h0000_0000);
        chk("status", {20'h0_0000, strap_q, 8'h00}, rd);
        chk("strap", 32'(strap_q), 32'(scfg));
        chk("run", 32'h0000_0007, {29'h0, pll, mac, host});
        wb(1, 8'h40, 32'hFFFF_FFFF);
        wb(0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        wb(1, ADR_PORT_PD, 32'(pd));
        wb(0, ADR_PORT_PD, 32'h0000_0000);
        chk("pd reg", {27'h000_0000, pd}, rd);
        chk("phy", {27'h000_0000, ~pd}, {27'h000_0000, phy});
        wb(1, ADR_QUIET, 32'h0000_0004);
        energy_q <= 5'h00;
        wb(1, ADR_PWR_CTRL, 32'({MODE_ENERGY_DETECT_POWER_DOWN, 3'b000}));
        for (n = 0; n < 300 && pll !== 1'b0; n++) @(posedge clock_in);
        chk("low", {24'h00_0000, 3'b000, ~pd}, {24'h00_0000, pll, mac, host, edet});
        energy_q <= 5'h01;
        repeat (60) @(posedge clock_in);
        chk("pulse", 32'h0000_0001, 32'(n_pulse > 0));
        chk("pd energy", 32'h0000_0000, 32'(pll));
        energy_q <= 5'h10;
        repeat (20) @(posedge clock_in);
        energy_q <= 5'h00;
        repeat (20) @(posedge clock_in);
        chk("short energy", 32'h0000_0000, 32'(pll));
        energy_q <= 5'h10;
        for (n = 0; n < 80 && pll !== 1'b1; n++) @(posedge clock_in);
        chk("wake", 32'h0000_0001, {31'h0, pll});
        chk("dwell", 32'h0000_0001, 32'(n >= 26));
        wb(1, ADR_PWR_CTRL, 32'({MODE_RSVD, 3'b000}));
        wb(0, ADR_STATUS, 32'h0000_0000);
        chk("rsvd", 32'(MODE_ENERGY_DETECT_POWER_DOWN), 32'(rd[1:0]));
        wb(1, ADR_PWR_CTRL, 32'({MODE_SOFT, 3'b000}));
        wb(0, ADR_STATUS, 32'h0000_0000);
        chk("soft", 32'(MODE_SOFT), 32'(rd[1:0]));
        chk("soft off", 32'h0000_0000, {24'h00_0000, pll, mac, host, phy});
        strap_q <= ~strap_q;
        wb(1, ADR_PWR_CTRL, 32'h0000_0000);
        repeat (5) @(posedge clock_in);
        chk("restrap", 32'(strap_q), 32'(scfg));
        wb(0, ADR_QUIET, 32'h0000_0000);
        chk("quiet", 32'(QUIET_RST), rd);
        wb(0, ADR_STATUS, 32'h0000_0000);
        chk("normal", 32'(MODE_NORMAL), 32'(rd[1:0]));
        wb(1, ADR_NODE_LO, node[31:0]);
        wb(1, ADR_NODE_HI, 32'(node[47:32]));
        wb(1, ADR_WAKE_CFG, 32'h0000_0C0A);
        link_q <= 5'h1F;
        repeat (10) @(posedge clock_in);
        wb(0, ADR_WAKE_STAT, 32'h0000_0000);
        chk("masked", 32'h0000_0000, rd);
        send_q <= 1'b1;
        @(posedge clock_in);
        send_q <= 1'b0;
        for (n = 0; n < 200 && pev_n !== 1'b0; n++) @(posedge clock_in);
        chk("event pin", 32'h0000_0001, {30'h0, pev_n, int_n});
        wb(0, ADR_WAKE_STAT, 32'h0000_0000);
        chk("pattern", 32'h0000_0004, rd);
        wb(1, ADR_WAKE_STAT, 32'h0000_0004);
        repeat (3) @(posedge clock_in);
        chk("cleared", 32'h0000_0001, {31'h0, pev_n});
        wb(1, ADR_WAKE_CFG, 32'h0000_1A0A);
        link_q <= 5'h00;
        repeat (5) @(posedge clock_in);
        link_q <= 5'h02;
        for (n = 0; n < 50 && int_n !== 1'b0; n++) @(posedge clock_in);
        chk("routed", 32'h0000_0002, {30'h0, pev_n, int_n});
        tally_and_finish();
    end
endmodule // tb_pmw_power_wake
